// ===== rtl/timer_irq_regs.sv
// axi4-lite register slave for timer status, interrupt enable, flags, set and clear
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`include "timer_irq_cfg.svh"

module timer_irq_regs (
	// clock and reset
	input wire logic                     aclk,
	input wire logic                     aresetn,
	// axi4-lite write address
	input wire logic [11:0]              s_axi_awaddr,
	input wire logic                     s_axi_awvalid,
	output logic                         s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0]              s_axi_wdata,
	input wire logic [3:0]               s_axi_wstrb,
	input wire logic                     s_axi_wvalid,
	output logic                         s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input wire logic                     s_axi_bready,
	// axi4-lite read address
	input wire logic [11:0]              s_axi_araddr,
	input wire logic                     s_axi_arvalid,
	output logic                         s_axi_arready,
	// axi4-lite read data
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input wire logic                     s_axi_rready,
	// timer core events, one-cycle pulses, plus the per-channel compare mode level
	input wire logic                     overflow_evt,
	input wire logic                     underflow_evt,
	input wire timer_irq_pkg::chan_vec_t chan_evt,
	input wire timer_irq_pkg::chan_vec_t capture_overrun_evt,
	input wire timer_irq_pkg::chan_vec_t chan_buf_write,
	input wire timer_irq_pkg::chan_vec_t chan_compare_mode,
	input wire logic                     limit_buf_write,
	input wire logic                     update_event,
	// channel mode and limit buffer to the core
	output timer_irq_pkg::mode_t         chan0_operating_sel,
	output timer_irq_pkg::mode_t         chan1_operating_sel,
	output timer_irq_pkg::mode_t         chan2_operating_sel,
	output timer_irq_pkg::limit_t        limit_buffer,
	// interrupt
	output logic                         irq
);
	import timer_irq_pkg::*;

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        aw_held;
		logic        w_held;
		logic [11:0] awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		irq_vec_t    enable;
		mode_t [2:0] mode;
		limit_t      limit_buf;
		irq_vec_t    sw_set;
		irq_vec_t    sw_clr;
		chan_vec_t   off_wr;
		logic        limit_wr;
		logic        irq;
	} reg_state_t;

	reg_state_t s_q;
	reg_state_t s_d;

	timer_evt_if evt ();
	chan_vec_t   chan_pending;
	logic        limit_pending;
	logic        wr_fire;
	logic [31:0] wmask;
	logic [31:0] wval;
	logic [31:0] rd_word;
	logic        rd_hit;
	logic        wr_hit;

	// ------------------------------------------------------------------
	// submodules
	// ------------------------------------------------------------------
	timer_irq_flags u_flags (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ev      (evt)
	);

	timer_buf_status u_buf (
		.aclk           (aclk),
		.aresetn        (aresetn),
		.buf_write      (chan_buf_write),
		.mode_off_write (s_q.off_wr),
		.compare_mode   (chan_compare_mode),
		.limit_write    (s_q.limit_wr || limit_buf_write),
		.update_event   (update_event),
		.chan_pending   (chan_pending),
		.limit_pending  (limit_pending)
	);

	// event routing into the flag bits
	always_comb begin
		evt.hw_set = '0;
		evt.hw_set[`BIT_OVERFLOW]  = overflow_evt;
		evt.hw_set[`BIT_UNDERFLOW] = underflow_evt;
		evt.hw_set[`BIT_EVENT0 +: `NUM_CHAN]   = chan_evt;
		evt.hw_set[`BIT_OVERRUN0 +: `NUM_CHAN] = capture_overrun_evt;
	end
	assign evt.sw_set = s_q.sw_set;
	assign evt.sw_clr = s_q.sw_clr;
	assign evt.enable = s_q.enable;

	// ------------------------------------------------------------------
	// write decode
	// ------------------------------------------------------------------
	// byte-lane mask from strobes
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			wmask[b*8 +: 8] = {8{s_q.wstrb[b]}};
		end
	end
	assign wval    = s_q.wdata & wmask;
	assign wr_fire = s_q.aw_held && s_q.w_held && !s_q.bvalid;
	always_comb begin
		case (s_q.awaddr)
			`OFS_IRQ_ENABLE, `OFS_IRQ_FLAG_SET, `OFS_IRQ_FLAG_CLR,
			`OFS_CHAN_MODE, `OFS_LIMIT_BUF: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// ------------------------------------------------------------------
	// read decode
	// ------------------------------------------------------------------
	// status word holds channel and limit pending bits
	always_comb begin
		rd_word = 32'h00000000;
		rd_hit  = 1'b1;
		case (s_axi_araddr)
			`OFS_STATUS: begin
				rd_word[`STAT_BUF0 +: `NUM_CHAN] = chan_pending;
				rd_word[`STAT_LIMIT] = limit_pending;
			end
			`OFS_IRQ_ENABLE:   rd_word[`IRQ_W-1:0] = s_q.enable;
			`OFS_IRQ_FLAGS:    rd_word[`IRQ_W-1:0] = evt.flags;
			`OFS_IRQ_FLAG_SET: rd_word = 32'h00000000;
			`OFS_IRQ_FLAG_CLR: rd_word = 32'h00000000;
			`OFS_CHAN_MODE:    rd_word[5:0] = {s_q.mode[2], s_q.mode[1], s_q.mode[0]};
			`OFS_LIMIT_BUF:    rd_word[`LIMIT_W-1:0] = s_q.limit_buf;
			default:           rd_hit = 1'b0;
		endcase
	end

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.sw_set   = '0;
		s_d.sw_clr   = '0;
		s_d.off_wr   = '0;
		s_d.limit_wr = 1'b0;
		s_d.irq      = evt.irq;
		// accept address and data in either order, one at a time
		s_d.awready = !s_q.aw_held && !s_axi_awready_take();
		s_d.wready  = !s_q.w_held && !s_axi_wready_take();
		if (s_axi_awvalid && s_q.awready) begin
			s_d.aw_held = 1'b1;
			s_d.awaddr  = s_axi_awaddr;
			s_d.awready = 1'b0;
		end
		if (s_axi_wvalid && s_q.wready) begin
			s_d.w_held = 1'b1;
			s_d.wdata  = s_axi_wdata;
			s_d.wstrb  = s_axi_wstrb;
			s_d.wready = 1'b0;
		end
		// perform the write and raise the response
		if (wr_fire) begin
			s_d.aw_held = 1'b0;
			s_d.w_held  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = wr_hit ? `AXI_OKAY : `AXI_SLVERR;
			case (s_q.awaddr)
				`OFS_IRQ_ENABLE: s_d.enable =
					(s_q.enable & ~irq_vec_t'(wmask)) |
					(irq_vec_t'(wval) & irq_vec_t'(`IRQ_MASK));
				`OFS_IRQ_FLAG_SET: s_d.sw_set =
					irq_vec_t'(wval) & irq_vec_t'(`IRQ_MASK);
				`OFS_IRQ_FLAG_CLR: s_d.sw_clr =
					irq_vec_t'(wval) & irq_vec_t'(`IRQ_MASK);
				`OFS_CHAN_MODE: begin
					for (int c = 0; c < `NUM_CHAN; c++) begin
						if (s_q.wstrb[0]) begin
							s_d.mode[c] = s_q.wdata[c*2 +: 2];
							s_d.off_wr[c] = (s_q.wdata[c*2 +: 2] == `MODE_OFF);
						end
					end
				end
				`OFS_LIMIT_BUF: begin
					s_d.limit_buf = (s_q.limit_buf & ~wmask[15:0]) | wval[15:0];
					s_d.limit_wr  = |s_q.wstrb[1:0];
				end
				default: ;
			endcase
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
			s_d.awready = 1'b1;
			s_d.wready  = 1'b1;
		end
		// read channel: one outstanding read
		if (s_axi_arvalid && s_q.arready) begin
			s_d.arready = 1'b0;
			s_d.rvalid  = 1'b1;
			s_d.rdata   = rd_word;
			s_d.rresp   = rd_hit ? `AXI_OKAY : `AXI_SLVERR;
		end
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid  = 1'b0;
			s_d.arready = 1'b1;
		end
	end

	// ready is dropped while a write waits for its response
	function automatic logic s_axi_awready_take();
		return s_q.bvalid || wr_fire;
	endfunction
	function automatic logic s_axi_wready_take();
		return s_q.bvalid || wr_fire;
	endfunction

	// register the state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q         <= '0;
			s_q.awready <= 1'b1;
			s_q.wready  <= 1'b1;
			s_q.arready <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign s_axi_awready       = s_q.awready;
	assign s_axi_wready        = s_q.wready;
	assign s_axi_bvalid        = s_q.bvalid;
	assign s_axi_bresp         = s_q.bresp;
	assign s_axi_arready       = s_q.arready;
	assign s_axi_rvalid        = s_q.rvalid;
	assign s_axi_rdata         = s_q.rdata;
	assign s_axi_rresp         = s_q.rresp;
	assign chan0_operating_sel = s_q.mode[0];
	assign chan1_operating_sel = s_q.mode[1];
	assign chan2_operating_sel = s_q.mode[2];
	assign limit_buffer        = s_q.limit_buf;
	assign irq                 = s_q.irq;
endmodule

// ===== include/timer_irq_cfg.svh
// register offsets, field positions and reset values of the timer status and irq block
`ifndef TIMER_IRQ_CFG_SVH
`define TIMER_IRQ_CFG_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define OFS_STATUS      12'h004
`define OFS_IRQ_ENABLE  12'h00C
`define OFS_IRQ_FLAGS   12'h010
`define OFS_IRQ_FLAG_SET 12'h014
`define OFS_IRQ_FLAG_CLR 12'h018
`define OFS_CHAN_MODE   12'h030
`define OFS_LIMIT_BUF   12'h020

// ----------------------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------------------
`define IRQ_W           11
`define IRQ_MASK        11'h773
`define BIT_OVERFLOW    0
`define BIT_UNDERFLOW   1
`define BIT_EVENT0      4
`define BIT_OVERRUN0    8
`define STAT_BUF0       8
`define STAT_LIMIT      11
`define NUM_CHAN        3
`define MODE_W          2
`define MODE_OFF        2'h0
`define LIMIT_W         16

// ----------------------------------------------------------------------------
// reset values and axi response codes
// ----------------------------------------------------------------------------
`define RST_IRQ         11'h000
`define RST_MODE        2'h0
`define RST_LIMIT_BUF   16'h0000
`define AXI_OKAY        2'h0
`define AXI_SLVERR      2'h2

`endif

// ===== include/timer_irq_pkg.sv
// types shared by the timer status and irq block
package timer_irq_pkg;
	typedef logic [10:0] irq_vec_t;
	typedef logic [2:0]  chan_vec_t;
	typedef logic [1:0]  mode_t;
	typedef logic [15:0] limit_t;
endpackage

// ===== include/timer_irq_if.sv
// event interface between the counter-side inputs and the flag logic
`timescale 1ns/1ps
interface timer_evt_if;
	import timer_irq_pkg::*;
	irq_vec_t hw_set;
	irq_vec_t sw_set;
	irq_vec_t sw_clr;
	irq_vec_t enable;
	irq_vec_t flags;
	logic     irq;
	modport src (output hw_set, output sw_set, output sw_clr, output enable,
		input flags, input irq);
	modport dst (input hw_set, input sw_set, input sw_clr, input enable,
		output flags, output irq);
endinterface

// ===== rtl/timer_irq_flags.sv
// sticky interrupt flags with hardware set, software set and clear, and masked request
`timescale 1ns/1ps
`include "timer_irq_cfg.svh"
module timer_irq_flags (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// events and register strobes
	timer_evt_if.dst ev
);
	import timer_irq_pkg::*;

	typedef struct packed {
		irq_vec_t flags;
		logic     irq;
	} flag_state_t;

	flag_state_t s_q;
	flag_state_t s_d;

	// set beats clear so no event lost in the clear cycle
	always_comb begin
		s_d = s_q;
		s_d.flags = ((s_q.flags & ~ev.sw_clr) | ev.sw_set | ev.hw_set)
			& irq_vec_t'(`IRQ_MASK);
		s_d.irq = |(s_d.flags & ev.enable);
	end

	// register the state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign ev.flags = s_q.flags;
	assign ev.irq   = s_q.irq;
endmodule

// ===== rtl/timer_buf_status.sv
// pending flags for channel compare buffers and the limit buffer
`timescale 1ns/1ps
`include "timer_irq_cfg.svh"
module timer_buf_status (
	// clock and reset
	input wire logic                     aclk,
	input wire logic                     aresetn,
	// channel side
	input wire timer_irq_pkg::chan_vec_t buf_write,
	input wire timer_irq_pkg::chan_vec_t mode_off_write,
	input wire timer_irq_pkg::chan_vec_t compare_mode,
	// limit side
	input wire logic                     limit_write,
	input wire logic                     update_event,
	// status
	output timer_irq_pkg::chan_vec_t     chan_pending,
	output logic                         limit_pending
);
	import timer_irq_pkg::*;

	typedef struct packed {
		chan_vec_t chan;
		logic      limit;
	} buf_state_t;

	buf_state_t s_q;
	buf_state_t s_d;

	// pending until the update event moves the value; off write clears
	always_comb begin
		s_d = s_q;
		for (int i = 0; i < `NUM_CHAN; i++) begin
			if (mode_off_write[i] || !compare_mode[i]) begin
				s_d.chan[i] = 1'b0;
			end else if (buf_write[i]) begin
				s_d.chan[i] = 1'b1;
			end else if (update_event) begin
				s_d.chan[i] = 1'b0;
			end
		end
		if (limit_write) begin
			s_d.limit = 1'b1;
		end else if (update_event) begin
			s_d.limit = 1'b0;
		end
	end

	// register the state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign chan_pending  = s_q.chan;
	assign limit_pending = s_q.limit;
endmodule

// ===== tb/timer_irq_regs_properties.sv
// checker of bus timing and interrupt behaviour of the timer irq register block
`timescale 1ns/1ps
`include "timer_irq_cfg.svh"
module timer_irq_props (
	// clock and reset
	input wire logic                     aclk,
	input wire logic                     aresetn,
	// register bus
	input wire logic                     s_axi_awvalid,
	input wire logic                     s_axi_awready,
	input wire logic                     s_axi_wvalid,
	input wire logic                     s_axi_wready,
	input wire logic [1:0]               s_axi_bresp,
	input wire logic                     s_axi_bvalid,
	input wire logic                     s_axi_bready,
	input wire logic                     s_axi_arvalid,
	input wire logic                     s_axi_arready,
	input wire logic [31:0]              s_axi_rdata,
	input wire logic [1:0]               s_axi_rresp,
	input wire logic                     s_axi_rvalid,
	input wire logic                     s_axi_rready,
	// events and outputs
	input wire logic                     overflow_evt,
	input wire logic                     underflow_evt,
	input wire timer_irq_pkg::chan_vec_t chan_evt,
	input wire timer_irq_pkg::chan_vec_t capture_overrun_evt,
	input wire timer_irq_pkg::mode_t     chan0_operating_sel,
	input wire timer_irq_pkg::limit_t    limit_buffer,
	input wire logic                     irq
);
	import timer_irq_pkg::*;
	typedef struct packed {
		logic [3:0] act;
		logic [3:0] wr;
	} cnt_t;
	cnt_t cnt_q;
	cnt_t cnt_d;
	// ------------------------------------------------------------------
	// cycles since the last cause, saturating
	// ------------------------------------------------------------------
	// zero in reset, so edges just after release are never blamed
	always_comb begin
		cnt_d = cnt_q;
		if (cnt_q.act != 4'hF) cnt_d.act = cnt_q.act + 4'h1;
		if (cnt_q.wr != 4'hF) cnt_d.wr = cnt_q.wr + 4'h1;
		if (overflow_evt || underflow_evt || (|chan_evt) || (|capture_overrun_evt))
			cnt_d.act = 4'h0;
		if (s_axi_wvalid && s_axi_wready) begin
			cnt_d.act = 4'h0;
			cnt_d.wr = 4'h0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) cnt_q <= '0;
		else cnt_q <= cnt_d;
	end
	// ------------------------------------------------------------------
	// properties
	// ------------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_b_due;
		##[1:3] s_axi_bvalid;
	endsequence
	AST_WRITE_ANSWER:
		assert property (s_wr_taken |-> s_b_due) else $error("write response missing");
	AST_READ_ANSWER:
		assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	AST_READ_HOLD:
		assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
			&& $stable(s_axi_rresp)) else $error("read answer dropped");
	AST_WRITE_HOLD:
		assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	AST_BUSY_READY:
		assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("ready while write outstanding");
	AST_UPPER_ZERO:
		assert property (s_axi_rvalid && s_axi_rresp == `AXI_OKAY |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read bits set");
	AST_IRQ_CAUSE:
		assert property ($rose(irq) |-> cnt_q.act <= 4'h4) else $error("irq rose without cause");
	AST_IRQ_DROP:
		assert property ($fell(irq) |-> cnt_q.wr <= 4'h4) else $error("irq fell without write");
	AST_CTRL_BY_WRITE:
		assert property (!$stable({chan0_operating_sel, limit_buffer}) |-> cnt_q.wr <= 4'h3)
		else $error("control output changed without write");
endmodule
bind timer_irq_regs timer_irq_props i_props (.*);

// ===== tb/test_timer_irq_regs.sv
// self-checking bench of the timer status and irq register block
`timescale 1ns/1ps
`include "timer_irq_cfg.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
	$display("BAD %0t got %h exp %h", $time, g, e); end end
module test_timer_irq_regs;
	import timer_irq_pkg::*;
	// ------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------
	localparam irq_vec_t flag_bits = 11'h773;
	logic aclk, aresetn, aw_valid, aw_ready, w_valid, w_ready, b_valid, b_ready;
	logic ar_valid, ar_ready, r_valid, r_ready, upd, irq;
	logic [11:0] aw_addr, ar_addr;
	logic [31:0] w_data, r_data;
	logic [1:0]  b_resp, r_resp, rs;
	irq_vec_t    ev;
	chan_vec_t   buf_wr, cmp_mode;
	mode_t       sel0, sel1, sel2;
	limit_t      lim;
	int          n_errors = 0;
	int          n_tests = 0;
	timer_irq_regs i_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready),
		.s_axi_wdata(w_data), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_valid), .s_axi_wready(w_ready),
		.s_axi_bresp(b_resp), .s_axi_bvalid(b_valid), .s_axi_bready(b_ready),
		.s_axi_araddr(ar_addr), .s_axi_arvalid(ar_valid), .s_axi_arready(ar_ready),
		.s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid), .s_axi_rready(r_ready),
		.overflow_evt(ev[0]), .underflow_evt(ev[1]), .chan_evt(ev[6:4]),
		.capture_overrun_evt(ev[10:8]), .chan_buf_write(buf_wr), .chan_compare_mode(cmp_mode),
		.limit_buf_write(1'b0), .update_event(upd), .chan0_operating_sel(sel0),
		.chan1_operating_sel(sel1), .chan2_operating_sel(sel2), .limit_buffer(lim), .irq(irq));
	// ------------------------------------------------------------------
	// bus and event drivers
	// ------------------------------------------------------------------
	// each driver starts one edge after the last so no signal is set twice in a step
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		bit done;
		@(posedge aclk);
		{aw_addr, w_data, aw_valid, w_valid, b_ready} <= {a, d, 3'b111};
		n = 0;
		done = 0;
		while (!done && n < 100) begin
			@(posedge aclk);
			n++;
			if (aw_valid && aw_ready) aw_valid <= 1'b0;
			if (w_valid && w_ready) w_valid <= 1'b0;
			if (b_valid) begin
				r = b_resp;
				b_ready <= 1'b0;
				done = 1;
			end
		end
		`CHK(done, 1'b1)
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		bit done;
		@(posedge aclk);
		{ar_addr, ar_valid, r_ready} <= {a, 2'b11};
		n = 0;
		done = 0;
		while (!done && n < 100) begin
			@(posedge aclk);
			n++;
			if (ar_valid && ar_ready) ar_valid <= 1'b0;
			if (r_valid) begin
				{d, r} = {r_data, r_resp};
				r_ready <= 1'b0;
				done = 1;
			end
		end
		`CHK(done, 1'b1)
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		`CHK(d, e)
		`CHK(r, `AXI_OKAY)
	endtask
	task automatic pulse(input irq_vec_t e, input chan_vec_t b, input logic u);
		@(posedge aclk);
		{ev, buf_wr, upd} <= {e, b, u};
		@(posedge aclk);
		{ev, buf_wr, upd} <= '0;
	endtask
	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_reset();
		rdc(`OFS_IRQ_ENABLE, 32'h0);
		rdc(`OFS_IRQ_FLAGS, 32'h0);
		rdc(`OFS_IRQ_FLAG_SET, 32'h0);
		rdc(`OFS_STATUS, 32'h0);
		`CHK(irq, 1'b0)
	endtask
	task automatic t_enable();
		wr(`OFS_IRQ_ENABLE, 32'h773, rs);
		rdc(`OFS_IRQ_ENABLE, 32'h773);
		wr(`OFS_IRQ_ENABLE, 32'h401, rs);
		rdc(`OFS_IRQ_ENABLE, 32'h401);
		wr(`OFS_IRQ_ENABLE, 32'h0, rs);
	endtask
	// each event alone: flag sticks, irq only once enabled, gone after clear
	task automatic t_events();
		for (int b = 0; b < 11; b++) begin
			if (!flag_bits[b]) continue;
			pulse(irq_vec_t'(1) << b, 3'b000, 1'b0);
			rdc(`OFS_IRQ_FLAGS, 32'h1 << b);
			`CHK(irq, 1'b0)
			wr(`OFS_IRQ_ENABLE, 32'h1 << b, rs);
			repeat (3) @(posedge aclk);
			`CHK(irq, 1'b1)
			wr(`OFS_IRQ_FLAG_CLR, 32'h1 << b, rs);
			repeat (3) @(posedge aclk);
			`CHK(irq, 1'b0)
			rdc(`OFS_IRQ_FLAGS, 32'h0);
		end
		wr(`OFS_IRQ_ENABLE, 32'h0, rs);
	endtask
	task automatic t_set_clear();
		wr(`OFS_IRQ_FLAG_SET, 32'h773, rs);
		rdc(`OFS_IRQ_FLAGS, 32'h773);
		wr(`OFS_IRQ_FLAG_SET, 32'h0, rs);
		wr(`OFS_IRQ_FLAGS, 32'h0, rs);
		rdc(`OFS_IRQ_FLAGS, 32'h773);
		wr(`OFS_IRQ_FLAG_CLR, 32'h121, rs);
		rdc(`OFS_IRQ_FLAGS, 32'h652);
		wr(`OFS_IRQ_FLAG_CLR, 32'h773, rs);
		rdc(`OFS_IRQ_FLAGS, 32'h0);
	endtask
	task automatic t_unmapped();
		logic [31:0] d;
		wr(12'h100, 32'h773, rs);
		`CHK(rs, `AXI_SLVERR)
		rd(12'h100, d, rs);
		`CHK(rs, `AXI_SLVERR)
		rdc(`OFS_IRQ_FLAGS, 32'h0);
	endtask
	task automatic t_status();
		cmp_mode <= 3'b000;
		pulse(11'h0, 3'b001, 1'b0);
		rdc(`OFS_STATUS, 32'h0);
		cmp_mode <= 3'b111;
		pulse(11'h0, 3'b001, 1'b0);
		rdc(`OFS_STATUS, 32'h100);
		pulse(11'h0, 3'b000, 1'b1);
		rdc(`OFS_STATUS, 32'h0);
		pulse(11'h0, 3'b110, 1'b0);
		wr(`OFS_CHAN_MODE, 32'h14, rs);
		`CHK({sel2, sel1, sel0}, 6'h14)
		rdc(`OFS_STATUS, 32'h600);
		wr(`OFS_CHAN_MODE, 32'h10, rs);
		rdc(`OFS_STATUS, 32'h400);
		wr(`OFS_CHAN_MODE, 32'h0, rs);
		rdc(`OFS_STATUS, 32'h0);
		wr(`OFS_LIMIT_BUF, 32'h1234, rs);
		`CHK(lim, 16'h1234)
		rdc(`OFS_STATUS, 32'h800);
		pulse(11'h0, 3'b000, 1'b1);
		rdc(`OFS_STATUS, 32'h0);
	endtask
	task automatic t_rereset();
		wr(`OFS_IRQ_FLAG_SET, 32'h773, rs);
		wr(`OFS_IRQ_ENABLE, 32'h773, rs);
		repeat (3) @(posedge aclk);
		`CHK(irq, 1'b1)
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(`OFS_IRQ_FLAGS, 32'h0);
		rdc(`OFS_IRQ_ENABLE, 32'h0);
		`CHK(irq, 1'b0)
	endtask
	task automatic give_verdict();
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// ------------------------------------------------------------------
	// clock, sequence and watchdog
	// ------------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	initial begin
		{aresetn, aw_valid, w_valid, b_ready, ar_valid, r_ready, upd} = '0;
		{aw_addr, ar_addr, w_data, ev, buf_wr, cmp_mode} = '0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_enable();
		t_events();
		t_set_clear();
		t_unmapped();
		t_status();
		t_rereset();
		give_verdict();
	end
	// whole run needs a few hundred cycles; this is far beyond
	initial begin
		repeat (20000) @(posedge aclk);
		n_errors++;
		give_verdict();
	end
endmodule
